/* verilog/msb_pkg.sv */
// Shared constants and types for the dual-die memory bus ends.
// Assumes a 50 MHz system clock and a link clock of half that rate.
package msb_pkg;
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_DIV = 2;
  localparam int LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
  localparam int POR_SEQ_NS = 2000;
  localparam int PROG_NS = 8000;
  localparam logic [15:0] POR_SEQ_CYC = 16'((POR_SEQ_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [15:0] PROG_CYC = 16'((PROG_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  // Selectable release delays, in link cycles
  localparam logic [15:0] TMO_CYC0 = 16'h0010;
  localparam logic [15:0] TMO_CYC1 = 16'h0040;
  localparam logic [15:0] TMO_CYC2 = 16'h0100;
  localparam logic [15:0] TMO_CYC3 = 16'h0400;
  // Frame shape, in link cycles
  localparam logic [3:0] CMD_HOLD = 4'h6;
  localparam logic [3:0] LAT_CYC = 4'h2;
  localparam logic [3:0] GAP_CYC = 4'h4;
  // Command byte fields, low-voltage variant flag and idle lane value
  localparam int CMD_READ_BIT = 7;
  localparam int ADDR_W = 4;
  localparam bit LOW_VOLTAGE = 1'b1;
  localparam logic [7:0] DQ_IDLE = 8'hFF;

  typedef logic [1:0] msb_tmo_sel_t;
  typedef logic [7:0] msb_byte_t;
  typedef logic [ADDR_W-1:0] msb_addr_t;

  typedef enum logic [2:0] {POR_SEQ = 3'b001, POR_TMO = 3'b010, POR_DONE = 3'b100} msb_por_e;
  typedef enum logic [3:0] {D_IDLE = 4'b0001, D_HEAD = 4'b0010, D_WR = 4'b0100, D_RD = 4'b1000} msb_dev_e;
  typedef enum logic [3:0] {H_IDLE = 4'b0001, H_CMD = 4'b0010, H_XFER = 4'b0100, H_GAP = 4'b1000} msb_host_e;
endpackage : msb_pkg

/* verilog/msb_bus_if.sv */
// Shared pins between host controller and the two-die memory.
// Assumes each end drives only its own side; pull-ups are modelled here.
`timescale 1ns/100ps
interface msb_bus_if;
  import msb_pkg::*;
  logic linkClk;
  logic clockComplement;
  logic flashSelectN;
  logic ramSelectN;
  msb_byte_t hostDq;
  logic hostDqOe;
  msb_byte_t devDq;
  logic devDqOe;
  logic hostStrb;
  logic hostStrbOe;
  logic devStrb;
  logic devStrbOe;
  logic hwRstOut;
  logic hwRstOe;
  logic evtOe;
  logic porOe;
  msb_byte_t dqLine;
  logic rwStrobeMask;
  logic hwResetLine;
  logic eventLine;
  logic porReleaseOutN;

  // ----------------------------------------------------------------
  // Wire resolution, enables active low
  // ----------------------------------------------------------------
  assign dqLine = !devDqOe ? devDq : (!hostDqOe ? hostDq : DQ_IDLE);
  assign rwStrobeMask = !devStrbOe ? devStrb : (!hostStrbOe ? hostStrb : 1'b0);
  assign hwResetLine = hwRstOe ? 1'b1 : hwRstOut;
  assign eventLine = evtOe;
  assign porReleaseOutN = porOe;

  modport host (output linkClk, clockComplement, flashSelectN, ramSelectN, hostDq, hostDqOe,
    hostStrb, hostStrbOe, hwRstOut, hwRstOe, input dqLine, rwStrobeMask, eventLine, porReleaseOutN);
  modport device (input linkClk, flashSelectN, ramSelectN, dqLine, rwStrobeMask, hwResetLine,
    output devDq, devDqOe, devStrb, devStrbOe, evtOe, porOe);
endinterface : msb_bus_if

/* verilog/msb_device.sv */
// Memory-side end: flash die and RAM die sharing one byte-wide link.
// Assumes the host makes the link clock and selects one die at a time.
//
// Functional notes
// - Eight lanes carry command and data
// - Flash pulls event low on event
// - Reset low reinitialises flash to idle
// - Reset low releases strobe and lanes
// - Reset input pulled high when open
// - Reset lets RAM frames run but releases their lanes and strobe
// - Power-on output low during power-on sequence
// - Hold low for chosen delay, then release
// - On release flash enters idle at once
// - Host never selects both dies together
// - Select one is flash, two is RAM
// - Clock complement only on low-voltage variant
// - Flash programming continues after deselect
// - Select fall starts, rise ends transaction
// - Selected die signals latency on strobe
// - Host masks RAM writes via strobe
`timescale 1ns/100ps
module msb_device
(
  input wire logic linkClk, // Link clock from host
  input wire logic rst_n, // Synchronous reset, low
  input wire logic ce, // Clock enable
  msb_bus_if.device bus, // Shared pins
  input wire logic ramRefreshPending, // RAM wants extra latency
  input wire msb_pkg::msb_tmo_sel_t porTimeoutSel, // Release delay choice
  output logic flashBusy, // Programming in progress
  output logic flashIdle, // Flash ready for frames
  output logic eventFlag // Event pending
);
  import msb_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] tmoCount(input msb_tmo_sel_t sel);
    case (sel)
      2'h0: tmoCount = TMO_CYC0;
      2'h1: tmoCount = TMO_CYC1;
      2'h2: tmoCount = TMO_CYC2;
      default: tmoCount = TMO_CYC3;
    endcase
  endfunction : tmoCount

  logic [11:0] syncA_reg;
  logic [11:0] syncB_reg;
  logic [1:0] selPrev_reg;
  msb_por_e por_reg;
  logic [15:0] porCnt_reg;
  msb_dev_e state_reg;
  logic dieRam_reg;
  logic readCmd_reg;
  msb_addr_t addr_reg;
  logic [3:0] cnt_reg;
  logic latBit_reg;
  msb_byte_t dqOut_reg;
  logic strobe_reg;
  logic [15:0] busyCnt_reg;
  logic event_reg;
  msb_byte_t mem [0:1][0:(1<<ADDR_W)-1];
  logic fSelN;
  logic rSelN;
  msb_byte_t dqIn;
  logic maskIn;
  logic hwRstN;
  logic fFall;
  logic rFall;
  logic activeRise;
  logic flashReady;
  logic dataWrite;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages on every host pin; all share one delay so bytes stay aligned
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      syncA_reg <= 12'hC01;
      syncB_reg <= 12'hC01;
    end
    else if (ce)
    begin
      syncA_reg <= {bus.flashSelectN, bus.ramSelectN, bus.dqLine, bus.rwStrobeMask, bus.hwResetLine};
      syncB_reg <= syncA_reg;
    end
  end

  assign fSelN = syncB_reg[11];
  assign rSelN = syncB_reg[10];
  assign dqIn = syncB_reg[9:2];
  assign maskIn = syncB_reg[1];
  assign hwRstN = syncB_reg[0];

  // Select edges
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
      selPrev_reg <= 2'h3;
    else if (ce)
      selPrev_reg <= {fSelN, rSelN};
  end

  assign fFall = selPrev_reg[1] && !fSelN;
  assign rFall = selPrev_reg[0] && !rSelN;
  assign activeRise = dieRam_reg ? (!selPrev_reg[0] && rSelN) : (!selPrev_reg[1] && fSelN);
  assign flashReady = (por_reg == POR_DONE) && hwRstN;

  // ----------------------------------------------------------------
  // Power-on sequence and release delay
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      por_reg <= POR_SEQ;
      porCnt_reg <= 16'h0000;
    end
    else if (ce)
    begin
      case (por_reg)
        POR_SEQ:
        begin
          porCnt_reg <= porCnt_reg + 16'h0001;
          if (porCnt_reg == POR_SEQ_CYC - 16'h0001)
          begin
            por_reg <= POR_TMO;
            porCnt_reg <= 16'h0000;
          end
        end
        POR_TMO:
        begin
          porCnt_reg <= porCnt_reg + 16'h0001;
          if (porCnt_reg == tmoCount(porTimeoutSel) - 16'h0001)
            por_reg <= POR_DONE;
        end
        POR_DONE: porCnt_reg <= 16'h0000;
        default: por_reg <= POR_SEQ;
      endcase
    end
  end

  // Open-drain release: enable low pulls the line down
  assign bus.porOe = (por_reg == POR_DONE);

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // A flash frame is dropped when reset or power-on holds the flash
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      state_reg <= D_IDLE;
      dieRam_reg <= 1'b0;
      readCmd_reg <= 1'b0;
      addr_reg <= '0;
      cnt_reg <= 4'h0;
      latBit_reg <= 1'b0;
    end
    else if (ce)
    begin
      case (state_reg)
        D_IDLE:
        begin
          cnt_reg <= 4'h0;
          if (rFall)
          begin
            state_reg <= D_HEAD;
            dieRam_reg <= 1'b1;
            latBit_reg <= ramRefreshPending;
          end
          else if (fFall && flashReady)
          begin
            state_reg <= D_HEAD;
            dieRam_reg <= 1'b0;
            latBit_reg <= 1'b0;
          end
        end
        D_HEAD:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          // Edge detect costs a cycle, so the last command byte shows one count early
          if (cnt_reg == CMD_HOLD - 4'h2)
          begin
            readCmd_reg <= dqIn[CMD_READ_BIT];
            addr_reg <= dqIn[ADDR_W-1:0];
            state_reg <= dqIn[CMD_READ_BIT] ? D_RD : D_WR;
          end
        end
        D_WR:
          if (!maskIn)
            addr_reg <= addr_reg + 1'b1;
        D_RD: addr_reg <= addr_reg + 1'b1;
        default: state_reg <= D_IDLE;
      endcase
      if (state_reg != D_IDLE && (activeRise || (!dieRam_reg && !flashReady)))
        state_reg <= D_IDLE;
    end
  end

  assign dataWrite = ce && state_reg == D_WR && !maskIn && !activeRise && (dieRam_reg || flashReady);

  // Storage, RAM die at index 1
  always_ff @(posedge linkClk)
  begin
    if (dataWrite)
      mem[dieRam_reg][addr_reg] <= dqIn;
  end

  // Read data and edge-aligned strobe from flops
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      dqOut_reg <= 8'h00;
      strobe_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg == D_RD)
      begin
        dqOut_reg <= mem[dieRam_reg][addr_reg];
        strobe_reg <= !strobe_reg;
      end
      else
        strobe_reg <= 1'b0;
    end
  end

  // Drivers: latency flag early in head, data during reads
  assign bus.devDq = dqOut_reg;
  assign bus.devStrb = (state_reg == D_HEAD) ? latBit_reg : strobe_reg;
  assign bus.devDqOe = !(hwRstN && state_reg == D_RD && cnt_reg == CMD_HOLD - 4'h1);
  assign bus.devStrbOe = !(hwRstN && ((state_reg == D_HEAD && cnt_reg < LAT_CYC) || state_reg == D_RD));

  // ----------------------------------------------------------------
  // Programming timer and event flag
  // ----------------------------------------------------------------
  // Timer runs regardless of selects so RAM can be used meanwhile
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      busyCnt_reg <= 16'h0000;
      event_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!hwRstN)
      begin
        busyCnt_reg <= 16'h0000;
        event_reg <= 1'b0;
      end
      else
      begin
        if (dataWrite && !dieRam_reg)
          busyCnt_reg <= PROG_CYC;
        else if (busyCnt_reg != 16'h0000)
          busyCnt_reg <= busyCnt_reg - 16'h0001;
        // Set wins over the clear on a flash select fall
        if (busyCnt_reg == 16'h0001 && !(dataWrite && !dieRam_reg))
          event_reg <= 1'b1;
        else if (fFall)
          event_reg <= 1'b0;
      end
    end
  end

  assign bus.evtOe = !event_reg;
  assign flashBusy = (busyCnt_reg != 16'h0000);
  assign flashIdle = flashReady && state_reg == D_IDLE;
  assign eventFlag = event_reg;
endmodule : msb_device

/* verilog/msb_host.sv */
// Host-side end: link clock divider, frame sequencer and write FIFO.
// Assumes the memory end samples every host pin through two flops.
`timescale 1ns/100ps
module msb_fifo
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, low
  input wire logic ce, // Clock enable
  input wire logic inValid, // Fill side valid
  output logic inReady, // Fill side ready
  input wire logic [WIDTH-1:0] inData, // Fill data
  output logic outValid, // Drain side valid
  input wire logic outReady, // Drain side ready
  output logic [WIDTH-1:0] outData // Drain data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push = ce && inValid && inReady;
  assign pop = ce && outValid && outReady;
  assign outData = mem[rd_reg];

  // Pointers wrap at a power-of-two depth
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= inData;
  end
endmodule : msb_fifo

module msb_host
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, low
  input wire logic ce, // Clock enable
  msb_bus_if.host bus, // Shared pins
  input wire logic cmdValid, // Frame request
  output logic cmdReady, // Frame accepted
  input wire logic cmdRead, // 1 read, 0 write
  input wire logic cmdFlash, // 1 flash, 0 RAM
  input wire msb_pkg::msb_addr_t cmdAddr, // Start address
  input wire logic [3:0] cmdLen, // Bytes, nonzero
  input wire logic wrValid, // Write byte valid
  output logic wrReady, // Write byte taken
  input wire msb_pkg::msb_byte_t wrData, // Write byte
  output logic rdValid, // Read byte pulse
  output msb_pkg::msb_byte_t rdData, // Read byte
  input wire logic hwResetReq, // Hold flash reset
  output logic flashEvent, // Event line low, synced
  output logic porActive // Power-on line low, synced
);
  import msb_pkg::*;
  msb_host_e state_reg;
  logic link_reg;
  logic tick;
  logic [3:0] cnt_reg;
  logic [3:0] len_reg;
  logic [3:0] done_reg;
  logic read_reg;
  logic flash_reg;
  msb_byte_t dq_reg;
  logic dqOe_reg;
  logic strb_reg;
  logic strbOe_reg;
  logic [10:0] sA_reg;
  logic [10:0] sB_reg;
  logic strbPrev_reg;
  logic fifoValid;
  msb_byte_t fifoData;
  logic pop;
  logic lastHead;
  logic rdEdge;

  // Link clock from divider, outputs move on its falling edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      link_reg <= 1'b0;
    else if (ce)
      link_reg <= !link_reg;
  end

  assign tick = ce && link_reg;
  assign bus.linkClk = link_reg;
  assign bus.clockComplement = LOW_VOLTAGE ? !link_reg : 1'b0;

  // synchronisers for event, power-on, strobe and lanes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sA_reg <= 11'h600;
      sB_reg <= 11'h600;
      strbPrev_reg <= 1'b0;
    end
    else if (ce)
    begin
      sA_reg <= {bus.eventLine, bus.porReleaseOutN, bus.rwStrobeMask, bus.dqLine};
      sB_reg <= sA_reg;
      strbPrev_reg <= sB_reg[8];
    end
  end

  assign flashEvent = !sB_reg[10];
  assign porActive = !sB_reg[9];
  assign rdEdge = ce && state_reg == H_XFER && read_reg && sB_reg[8] != strbPrev_reg && done_reg != len_reg;

  msb_fifo #(.WIDTH(8), .DEPTH(4)) wrFifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrData),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoData)
  );

  // Drain stalls outside write frames, so the FIFO can fill
  assign lastHead = state_reg == H_CMD && cnt_reg == CMD_HOLD - 4'h1;
  assign pop = tick && !read_reg && (lastHead || (state_reg == H_XFER && done_reg != len_reg));
  // Flash frames wait while reset or power-on holds the flash
  assign cmdReady = tick && state_reg == H_IDLE && !(cmdFlash && (porActive || hwResetReq));

  // Frame sequencer; only one select is ever low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= H_IDLE;
      cnt_reg <= 4'h0;
      len_reg <= 4'h0;
      done_reg <= 4'h0;
      read_reg <= 1'b0;
      flash_reg <= 1'b0;
      dq_reg <= 8'h00;
      dqOe_reg <= 1'b1;
      strb_reg <= 1'b0;
      strbOe_reg <= 1'b1;
      rdValid <= 1'b0;
      rdData <= 8'h00;
    end
    else if (ce)
    begin
      rdValid <= rdEdge;
      if (rdEdge)
      begin
        rdData <= sB_reg[7:0];
        done_reg <= done_reg + 4'h1;
      end
      if (tick)
      begin
        case (state_reg)
          H_IDLE:
            if (cmdValid && cmdReady)
            begin
              state_reg <= H_CMD;
              read_reg <= cmdRead;
              flash_reg <= cmdFlash;
              len_reg <= cmdLen;
              done_reg <= 4'h0;
              cnt_reg <= 4'h0;
              dq_reg <= {cmdRead, 3'h0, cmdAddr};
              dqOe_reg <= 1'b0;
            end
          H_CMD:
          begin
            cnt_reg <= cnt_reg + 4'h1;
            if (lastHead)
            begin
              state_reg <= H_XFER;
              dqOe_reg <= read_reg;
              strbOe_reg <= read_reg;
            end
          end
          H_XFER:
            if (done_reg == len_reg)
            begin
              state_reg <= H_GAP;
              cnt_reg <= 4'h0;
              dqOe_reg <= 1'b1;
              strbOe_reg <= 1'b1;
            end
          H_GAP:
          begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == GAP_CYC - 4'h1)
              state_reg <= H_IDLE;
          end
          default: state_reg <= H_IDLE;
        endcase
        // Empty FIFO sends a masked filler byte instead of stalling the link
        if (!read_reg && (lastHead || state_reg == H_XFER))
        begin
          dq_reg <= fifoData;
          strb_reg <= !fifoValid;
          if (pop && fifoValid)
            done_reg <= done_reg + 4'h1;
        end
      end
    end
  end

  assign bus.flashSelectN = !(flash_reg && (state_reg == H_CMD || state_reg == H_XFER));
  assign bus.ramSelectN = !(!flash_reg && (state_reg == H_CMD || state_reg == H_XFER));
  assign bus.hostDq = dq_reg;
  assign bus.hostDqOe = dqOe_reg;
  assign bus.hostStrb = strb_reg;
  assign bus.hostStrbOe = strbOe_reg;
  assign bus.hwRstOut = 1'b0;
  assign bus.hwRstOe = !hwResetReq;
endmodule : msb_host

/* sim/msb_bus_sva.sv */
// Checker for the shared memory link pins.
// Assumes the memory end reset, sampled on the link clock.
`timescale 1ns/100ps
module msb_bus_sva
#(
  parameter int POR_HOLD = 66
)
(
  input wire logic linkClk, // Link clock
  input wire logic rst_n, // Memory end reset
  input wire logic clockComplement, // Inverted clock
  input wire logic flashSelectN, // Flash select
  input wire logic ramSelectN, // RAM select
  input wire logic hostDqOe, // Host lane enable
  input wire logic devDqOe, // Device lane enable
  input wire logic devStrbOe, // Device strobe enable
  input wire logic hwResetLine, // Flash reset line
  input wire logic evtOe, // Event line
  input wire logic porOe // Power-on line
);
  logic [11:0] porCnt;
  // Link cycles since reset; saturates so it never wraps
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
      porCnt <= 12'h000;
    else if (porCnt != 12'hFFF)
      porCnt <= porCnt + 12'h001;
  end
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!rst_n);
  a_one_select: assert property (flashSelectN || ramSelectN)
    else $error("both selects low");
  a_comp_clock: assert property (clockComplement != linkClk)
    else $error("complement clock wrong");
  a_no_fight: assert property (hostDqOe || devDqOe)
    else $error("lanes driven by both ends");
  a_reset_release: assert property (!hwResetLine [*4] |-> devDqOe && devStrbOe)
    else $error("drivers on during reset");
  a_por_low: assert property (porCnt < 12'(POR_HOLD - 2) |-> !porOe)
    else $error("power-on line released early");
  a_por_release: assert property (porCnt == 12'(POR_HOLD + 4) |-> porOe)
    else $error("power-on line held too long");
  a_strobe_head: assert property ($fell(flashSelectN) || $fell(ramSelectN) |-> ##[1:4] !devStrbOe)
    else $error("no latency strobe");
  a_select_hold: assert property ($fell(flashSelectN) |=> !flashSelectN [*5])
    else $error("flash select too short");
  a_gap_after: assert property ($rose(flashSelectN) || $rose(ramSelectN) |=> (flashSelectN && ramSelectN) [*3])
    else $error("gap too short");
  a_event_clear: assert property (!evtOe && $fell(flashSelectN) |-> ##[1:5] evtOe)
    else $error("event not cleared");
  a_quiet_idle: assert property ((flashSelectN && ramSelectN) [*4] |-> devDqOe)
    else $error("lanes driven when idle");
endmodule : msb_bus_sva

/* sim/tb_top.sv */
// Bench joining host and memory ends over the shared pins.
// Assumes the host makes the link clock; inputs change at falling clk.
`timescale 1ns/100ps
module tb_top;
  import msb_pkg::*;
  logic clk, hostRstN = 1'b0, devRstN = 1'b0, cmdReady, wrReady, rdValid, flashEvent, porActive;
  logic cmdValid = 1'b0, cmdRead = 1'b0, cmdFlash = 1'b0, wrValid = 1'b0, hwResetReq = 1'b0;
  logic ramRefreshPending = 1'b0, flashBusy, flashIdle, eventFlag;
  logic [3:0] cmdLen = 4'h1;
  msb_addr_t cmdAddr = 4'h0, a;
  msb_byte_t wrData = 8'h00, rdData, ramExp [16], flashExp [16];
  logic [31:0] seed = 32'h00008CF2;
  int fail_count = 0, checks = 0, n;
  msb_bus_if msb_bus_if_inst ();
  msb_host msb_host_inst (.clk(clk), .rst_n(hostRstN), .ce(1'b1), .bus(msb_bus_if_inst.host),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdFlash(cmdFlash), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
    .rdData(rdData), .hwResetReq(hwResetReq), .flashEvent(flashEvent), .porActive(porActive));
  msb_device msb_device_inst (.linkClk(msb_bus_if_inst.linkClk), .rst_n(devRstN), .ce(1'b1),
    .bus(msb_bus_if_inst.device), .ramRefreshPending(ramRefreshPending), .porTimeoutSel(2'b00),
    .flashBusy(flashBusy), .flashIdle(flashIdle), .eventFlag(eventFlag));
  msb_bus_sva #(.POR_HOLD(int'(POR_SEQ_CYC + TMO_CYC0))) msb_bus_sva_inst (.linkClk(msb_bus_if_inst.linkClk),
    .rst_n(devRstN), .clockComplement(msb_bus_if_inst.clockComplement), .flashSelectN(msb_bus_if_inst.flashSelectN),
    .ramSelectN(msb_bus_if_inst.ramSelectN), .hostDqOe(msb_bus_if_inst.hostDqOe), .devDqOe(msb_bus_if_inst.devDqOe),
    .devStrbOe(msb_bus_if_inst.devStrbOe), .hwResetLine(msb_bus_if_inst.hwResetLine), .evtOe(msb_bus_if_inst.evtOe),
    .porOe(msb_bus_if_inst.porOe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic summarize();
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic hang();
    fail_count++;
    summarize();
  endtask : hang
  task automatic cmp8(input msb_byte_t got, input msb_byte_t exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1
  function automatic logic lvl(input int w);
    return (w == 0) ? porActive : ((w == 1) ? flashEvent : flashBusy);
  endfunction : lvl
  // Bounded wait on a level; returns cycles spent
  task automatic waitfor(input int w, input logic v, output int c);
    for (c = 0; c < 2000 && lvl(w) !== v; c++)
      @(negedge clk);
    if (c == 2000)
      hang();
  endtask : waitfor
  // Request held until the accepting edge, then dropped
  task automatic send(input logic r, input logic f, input msb_addr_t ad, input int len);
    int i;
    void'(rnd());
    ramRefreshPending = seed[7];
    cmdValid = 1'b1;
    cmdRead = r;
    cmdFlash = f;
    cmdAddr = ad;
    cmdLen = 4'(len);
    for (i = 0; i < 400 && cmdReady !== 1'b1; i++)
      @(negedge clk);
    if (i == 400)
      hang();
    @(negedge clk);
    cmdValid = 1'b0;
    @(negedge clk);
  endtask : send
  task automatic push(input msb_byte_t d);
    int i;
    wrValid = 1'b1;
    wrData = d;
    for (i = 0; i < 400 && wrReady !== 1'b1; i++)
      @(negedge clk);
    if (i == 400)
      hang();
    @(negedge clk);
    wrValid = 1'b0;
    @(negedge clk);
  endtask : push
  // Buffer filled first, so no masked filler enters the frame
  task automatic wr(input logic f, input msb_addr_t ad, input int len);
    msb_byte_t d;
    for (int k = 0; k < len; k++)
    begin
      d = msb_byte_t'(rnd());
      if (f)
        flashExp[ad + k] = d;
      else
        ramExp[ad + k] = d;
      push(d);
    end
    if (len == 4)
      cmp1(wrReady, 1'b0);
    send(1'b0, f, ad, len);
  endtask : wr
  task automatic rd(input logic f, input msb_addr_t ad, input int len);
    int k;
    int i;
    k = 0;
    send(1'b1, f, ad, len);
    for (i = 0; i < 600 && k < len; i++)
    begin
      if (rdValid === 1'b1)
      begin
        cmp8(rdData, f ? flashExp[ad + k] : ramExp[ad + k]);
        k++;
      end
      @(negedge clk);
    end
    if (k < len)
      hang();
  endtask : rd
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    hostRstN = 1'b1;
    repeat (10) @(negedge clk);
    devRstN = 1'b1;
    @(negedge clk);
    cmp1(porActive, 1'b1);
    waitfor(0, 1'b0, n);
    cmp1(n >= int'(POR_SEQ_CYC + TMO_CYC0) * LINK_DIV - 8, 1'b1);
    repeat (4) @(negedge clk);
    cmp1(flashIdle, 1'b1);
    // Random RAM traffic, first pass full buffer at top address
    for (int j = 0; j < 4; j++)
    begin
      n = (j == 0) ? 4 : 1 + int'(rnd() % 4);
      a = (j == 0) ? 4'hC : msb_addr_t'(rnd() % 13);
      wr(1'b0, a, n);
      rd(1'b0, a, n);
    end
    wr(1'b1, 4'h3, 1);
    waitfor(2, 1'b1, n);
    wr(1'b0, 4'h0, 2);
    rd(1'b0, 4'h0, 2);
    cmp1(flashBusy, 1'b1);
    waitfor(1, 1'b1, n);
    cmp1(eventFlag, 1'b1);
    rd(1'b1, 4'h3, 1);
    repeat (10) @(negedge clk);
    cmp1(flashEvent, 1'b0);
    // Reset in mid-program; flash frames refused meanwhile
    wr(1'b1, 4'h5, 1);
    waitfor(2, 1'b1, n);
    hwResetReq = 1'b1;
    cmdValid = 1'b1;
    cmdFlash = 1'b1;
    repeat (20)
    begin
      @(negedge clk);
      cmp1(cmdReady, 1'b0);
    end
    cmdValid = 1'b0;
    cmp1(msb_bus_if_inst.hwResetLine, 1'b0);
    cmp1(flashBusy, 1'b0);
    cmp1(eventFlag, 1'b0);
    hwResetReq = 1'b0;
    repeat (10) @(negedge clk);
    cmp1(flashIdle, 1'b1);
    cmp1(msb_bus_if_inst.hwResetLine, 1'b1);
    rd(1'b0, 4'h0, 2);
    repeat (10) @(negedge clk);
    cmp8(msb_bus_if_inst.dqLine, DQ_IDLE);
    summarize();
  end
endmodule : tb_top
